// [verilog/leic_irq_ctrl.sv]
`timescale 1ns/100ps
// What this block does
// - GPIO, loop lock and peripheral inputs in any combination can raise requests
// - Each source owns a flag set by an input edge, not level, except GPIO flags whose trigger select is clear
// - Some sources rising only; others have separate rise and fall flags
// - Flags are readable at any time
// - Each input has a live status bit showing its present value, the debounced level for GPIO pins with debounce enabled
// - Per-flag mask; masked flags still latch but do not request
// - Request is OR of unmasked flags, held until all are cleared
// - Flags stay set until software writes one to clear
// - GPIO triggers selectable edge or level via rise and fall selects; fall level mode fires only while the rise select is set
// - Optional per-pin GPIO debounce clocked from the 32 kHz clock
// - Global mask blocks the request output
// - Summary status shows OR of unmasked flags, ignoring global mask
// - Request pin active low at reset; polarity bit inverts it
// - Pin drive selectable between push-pull and open drain
// - GPIO copy of the request ignores pin polarity
// - After reset only boot-complete is unmasked
// - Polarity 0 is active high, 1 active low; resets to 1
// - Global mask resets to 0; 1 blocks the request
module leic_irq_ctrl
  import leic_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  input  wire logic                  bootDone,
  input  wire logic                  loopLock,
  input  wire logic [NUM_PERIPH-1:0] periphEvent,
  input  wire logic [NUM_GPIO-1:0]   gpioPin,
  input  wire logic                  clk32k,
  input  wire logic [NUM_GPIO-1:0]   gpioDebounceEnable,
  input  wire logic [NUM_GPIO-1:0]   gpioRisingTriggerSelect,
  input  wire logic [NUM_GPIO-1:0]   gpioFallingTriggerSelect,
  input  wire logic [NUM_FLAGS-1:0]  flagClearWrite,
  input  wire logic                  flagClearStrobe,
  input  wire logic [NUM_FLAGS-1:0]  maskWrite,
  input  wire logic                  maskStrobe,
  input  wire logic [2:0]            pinCfgWrite,
  input  wire logic                  pinCfgStrobe,
  output logic      [NUM_FLAGS-1:0]  flags,
  output logic      [NUM_FLAGS-1:0]  maskBits,
  output logic      [NUM_INPUTS-1:0] liveStatus,
  output logic                       requestGlobalMask,
  output logic                       requestPinPolarity,
  output logic                       requestPinDriveType,
  output logic                       requestSummaryStatus,
  output logic                       requestPinOut,
  output logic                       requestPinOe_n,
  output logic                       requestGpioOut
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Pins and the 32 kHz clock are asynchronous; sibling logic inputs are not
  logic [NUM_GPIO:0] syncA_q, syncB_q;
  logic [NUM_GPIO:0] syncA_d, syncB_d;
  logic              tickPrev_q, tickPrev_d;
  logic              tick32k;

  always_comb begin
    syncA_d    = {clk32k, gpioPin};
    syncB_d    = syncA_q;
    tickPrev_d = syncB_q[NUM_GPIO];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncA_q    <= '0;
      syncB_q    <= '0;
      tickPrev_q <= 1'b0;
    end else if (clkEn) begin
      syncA_q    <= syncA_d;
      syncB_q    <= syncB_d;
      tickPrev_q <= tickPrev_d;
    end
  end

  assign tick32k = syncB_q[NUM_GPIO] & ~tickPrev_q;

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  leic_src_if src ();

  leic_debounce u_debounce (
    .core_clk       (core_clk),
    .rst            (rst),
    .clkEn          (clkEn),
    .tick32k        (tick32k),
    .gpioSync       (syncB_q[NUM_GPIO-1:0]),
    .debounceEnable (gpioDebounceEnable),
    .src            (src.filt)
  );

  // ----------------------------------------
  // Edge detection and flags
  // ----------------------------------------
  logic [NUM_INPUTS-1:0] live, prev_q, prev_d;
  logic [NUM_FLAGS-1:0]  flag_q, flag_d, evt;
  logic [NUM_FLAGS-1:0]  mask_q, mask_d;
  logic                  gmask_q, gmask_d, pol_q, pol_d, drv_q, drv_d;
  logic [NUM_INPUTS-1:0] rise, fall;

  assign live = {src.gpioLevel, periphEvent, loopLock, bootDone};
  assign rise = live & ~prev_q;
  assign fall = ~live & prev_q;

  // Trigger select: edge when set, level otherwise
  function automatic logic trig_evt(input logic sel, input logic edgeSeen, input logic lvl);
    return sel ? edgeSeen : lvl;
  endfunction

  always_comb begin
    prev_d = live;
    evt    = '0;
    evt[FLAG_BOOT]      = rise[IN_BOOT];
    evt[FLAG_LOCK_RISE] = rise[IN_LOCK];
    evt[FLAG_LOCK_FALL] = fall[IN_LOCK];
    for (int i = 0; i < NUM_PERIPH; i++) evt[FLAG_PERIPH0 + i] = rise[IN_PERIPH0 + i];
    for (int i = 0; i < NUM_GPIO; i++) begin
      // Select clear: level mode, flag refires while held; fall level also needs the rise select set
      evt[FLAG_GPIO_RISE + i] = trig_evt(gpioRisingTriggerSelect[i],
        rise[IN_GPIO0 + i], live[IN_GPIO0 + i]);
      evt[FLAG_GPIO_FALL + i] = trig_evt(gpioFallingTriggerSelect[i],
        fall[IN_GPIO0 + i], ~live[IN_GPIO0 + i] & gpioRisingTriggerSelect[i]);
    end
    // Set beats clear; zero bits in the clear word keep their flag
    flag_d = flagClearStrobe ? ((flag_q & ~flagClearWrite) | evt)
                             : (flag_q | evt);
    mask_d  = maskStrobe ? maskWrite : mask_q;
    gmask_d = pinCfgStrobe ? pinCfgWrite[CFG_GMASK_BIT] : gmask_q;
    pol_d   = pinCfgStrobe ? pinCfgWrite[CFG_POL_BIT] : pol_q;
    drv_d   = pinCfgStrobe ? pinCfgWrite[CFG_DRIVE_BIT] : drv_q;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Inputs assumed low at reset; a high level counts as an edge
      prev_q  <= '0;
      flag_q  <= '0;
      mask_q  <= MASK_RESET;
      gmask_q <= GLOBAL_MASK_RESET;
      pol_q   <= POLARITY_RESET;
      drv_q   <= DRIVE_TYPE_RESET;
    end else if (clkEn) begin
      prev_q  <= prev_d;
      flag_q  <= flag_d;
      mask_q  <= mask_d;
      gmask_q <= gmask_d;
      pol_q   <= pol_d;
      drv_q   <= drv_d;
    end
  end

  // ----------------------------------------
  // Request outputs
  // ----------------------------------------
  logic reqRaw, reqGated, pinLevel;

  assign reqRaw   = |(flag_q & ~mask_q);
  assign reqGated = reqRaw & ~gmask_q;
  assign pinLevel = reqGated ^ pol_q;

  assign flags                = flag_q;
  assign maskBits             = mask_q;
  assign liveStatus           = live;
  assign requestGlobalMask    = gmask_q;
  assign requestPinPolarity   = pol_q;
  assign requestPinDriveType  = drv_q;
  assign requestSummaryStatus = reqRaw;
  // Open drain only pulls low; the high level comes from the pull-up
  assign requestPinOut        = pinLevel;
  assign requestPinOe_n       = drv_q & pinLevel;
  assign requestGpioOut       = reqGated;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sticky;
    @(posedge core_clk) disable iff (rst)
      (clkEn && flag_q[FLAG_BOOT] && !(flagClearStrobe && flagClearWrite[FLAG_BOOT]))
      |=> flag_q[FLAG_BOOT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_zero_keeps;
    @(posedge core_clk) disable iff (rst)
      (clkEn && flagClearStrobe && !flagClearWrite[FLAG_LOCK_RISE] && flag_q[FLAG_LOCK_RISE])
      |=> flag_q[FLAG_LOCK_RISE];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_edge_sets;
    @(posedge core_clk) disable iff (rst)
      (clkEn && rise[1]) |=> flag_q[FLAG_LOCK_RISE];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("rise not latched");

  property p_fall_sets;
    @(posedge core_clk) disable iff (rst)
      (clkEn && fall[1]) |=> flag_q[FLAG_LOCK_FALL];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall not latched");

  property p_summary;
    @(posedge core_clk) disable iff (rst)
      requestSummaryStatus == |(flags & ~maskBits);
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  property p_gmask;
    @(posedge core_clk) disable iff (rst)
      requestGlobalMask |-> (requestPinOut == requestPinPolarity) && !requestGpioOut;
  endproperty
  a_gmask: assert property (p_gmask) else $error("global mask leaked");

  property p_polarity;
    @(posedge core_clk) disable iff (rst)
      requestPinOut == (requestGpioOut ^ requestPinPolarity);
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin sense wrong");

  property p_od;
    @(posedge core_clk) disable iff (rst)
      (requestPinDriveType && requestPinOut) |-> requestPinOe_n;
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");

  property p_reset_vals;
    @(posedge core_clk) $fell(rst) |-> requestPinPolarity && !requestGlobalMask
      && maskBits == MASK_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_freeze;
    @(posedge core_clk) disable iff (rst)
      !clkEn |=> $stable(flag_q) && $stable(mask_q) && $stable(pol_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_clear_works;
    @(posedge core_clk) disable iff (rst)
      (clkEn && flagClearStrobe && flagClearWrite[FLAG_LOCK_RISE] && !evt[FLAG_LOCK_RISE])
      |=> !flag_q[FLAG_LOCK_RISE];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("clear ignored");

  property p_no_level_set;
    @(posedge core_clk) disable iff (rst)
      (clkEn && !rise[IN_LOCK] && !flag_q[FLAG_LOCK_RISE]) |=> !flag_q[FLAG_LOCK_RISE];
  endproperty
  a_no_level_set: assert property (p_no_level_set) else $error("set by level");

  property p_masked_latch;
    @(posedge core_clk) disable iff (rst)
      (clkEn && rise[IN_PERIPH0] && mask_q[FLAG_PERIPH0]) |=> flag_q[FLAG_PERIPH0];
  endproperty
  a_masked_latch: assert property (p_masked_latch) else $error("masked lost");

  property p_level_mode;
    @(posedge core_clk) disable iff (rst)
      (clkEn && !gpioRisingTriggerSelect[0] && live[IN_GPIO0]) |=> flag_q[FLAG_GPIO_RISE];
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("level not latched");

  property p_cmos_drives;
    @(posedge core_clk) disable iff (rst)
      !requestPinDriveType |-> !requestPinOe_n;
  endproperty
  a_cmos_drives: assert property (p_cmos_drives) else $error("push-pull released");

  property p_gpio_copy;
    @(posedge core_clk) disable iff (rst)
      requestGpioOut == (requestSummaryStatus && !requestGlobalMask);
  endproperty
  a_gpio_copy: assert property (p_gpio_copy) else $error("gpio copy wrong");

  property p_pol_load;
    @(posedge core_clk) disable iff (rst)
      (clkEn && pinCfgStrobe) |=> requestPinPolarity == $past(pinCfgWrite[CFG_POL_BIT]);
  endproperty
  a_pol_load: assert property (p_pol_load) else $error("polarity not loaded");

  property p_gmask_load;
    @(posedge core_clk) disable iff (rst)
      (clkEn && pinCfgStrobe) |=> requestGlobalMask == $past(pinCfgWrite[CFG_GMASK_BIT]);
  endproperty
  a_gmask_load: assert property (p_gmask_load) else $error("mask not loaded");

  property p_reset_pin;
    @(posedge core_clk) $fell(rst) |-> requestPinOut && requestPinOe_n;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("pin active at reset");

  c_boot:  cover property (@(posedge core_clk) disable iff (rst) $rose(flag_q[FLAG_BOOT]));
  c_clear: cover property (@(posedge core_clk) disable iff (rst) $fell(reqRaw));
  c_gpio:  cover property (@(posedge core_clk) disable iff (rst)
    $rose(flag_q[FLAG_GPIO_FALL]));
  c_od:    cover property (@(posedge core_clk) disable iff (rst)
    requestPinDriveType && reqGated);
  c_freeze: cover property (@(posedge core_clk) disable iff (rst)
    !clkEn && |evt);
endmodule

// [inc/leic_pkg.sv]
package leic_pkg;
  // Source set: GPIO pins, loop lock, peripheral flags, boot done
  localparam int NUM_GPIO   = 4;
  localparam int NUM_PERIPH = 4;
  // Flag vector layout
  localparam int FLAG_BOOT      = 0;
  localparam int FLAG_LOCK_RISE = 1;
  localparam int FLAG_LOCK_FALL = 2;
  localparam int FLAG_PERIPH0   = 3;
  localparam int FLAG_GPIO_RISE = FLAG_PERIPH0 + NUM_PERIPH;
  localparam int FLAG_GPIO_FALL = FLAG_GPIO_RISE + NUM_GPIO;
  localparam int NUM_FLAGS      = FLAG_GPIO_FALL + NUM_GPIO;
  localparam int NUM_INPUTS     = 2 + NUM_PERIPH + NUM_GPIO;
  // Live input vector layout
  localparam int IN_BOOT    = 0;
  localparam int IN_LOCK    = 1;
  localparam int IN_PERIPH0 = 2;
  localparam int IN_GPIO0   = IN_PERIPH0 + NUM_PERIPH;
  // Pin config word bit positions
  localparam int CFG_DRIVE_BIT = 0;
  localparam int CFG_POL_BIT   = 1;
  localparam int CFG_GMASK_BIT = 2;
  // Reset values
  localparam logic [NUM_FLAGS-1:0] MASK_RESET =
    ~(NUM_FLAGS'(1) << FLAG_BOOT);
  localparam logic POLARITY_RESET    = 1'b1;
  localparam logic DRIVE_TYPE_RESET  = 1'b1;
  localparam logic GLOBAL_MASK_RESET = 1'b0;
  // Debounce: three stable 32 kHz samples
  localparam int        DEB_STABLE_SAMPLES = 3;
  localparam logic [1:0] DEB_COUNT_MAX = 2'(DEB_STABLE_SAMPLES - 1);
endpackage

// [inc/leic_src_if.sv]
`timescale 1ns/100ps
// Conditioned GPIO levels from the debounce filter to the flag logic
interface leic_src_if;
  logic [leic_pkg::NUM_GPIO-1:0] gpioLevel;
  modport filt (output gpioLevel);
  modport core (input gpioLevel);
endinterface

// [verilog/leic_debounce.sv]
`timescale 1ns/100ps
module leic_debounce
  import leic_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  input  wire logic                tick32k,
  input  wire logic [NUM_GPIO-1:0] gpioSync,
  input  wire logic [NUM_GPIO-1:0] debounceEnable,
  leic_src_if.filt                 src
);
  logic [NUM_GPIO-1:0] filt_q, filt_d;
  logic [1:0]          cnt_q [NUM_GPIO];
  logic [1:0]          cnt_d [NUM_GPIO];

  // ----------------------------------------
  // Per-pin stability filter on 32 kHz ticks
  // ----------------------------------------
  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < NUM_GPIO; i++) begin
      cnt_d[i] = cnt_q[i];
      if (gpioSync[i] == filt_q[i]) begin
        cnt_d[i] = 2'h0;
      end else if (tick32k) begin
        // Pulses shorter than the window never reach the flags
        if (cnt_q[i] == DEB_COUNT_MAX) begin
          filt_d[i] = gpioSync[i];
          cnt_d[i]  = 2'h0;
        end else begin
          cnt_d[i] = cnt_q[i] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_q <= '0;
      for (int i = 0; i < NUM_GPIO; i++) cnt_q[i] <= 2'h0;
    end else if (clkEn) begin
      filt_q <= filt_d;
      for (int i = 0; i < NUM_GPIO; i++) cnt_q[i] <= cnt_d[i];
    end
  end

  assign src.gpioLevel = (debounceEnable & filt_q) | (~debounceEnable & gpioSync);
endmodule

// [bench/leic_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Host side of the request pin
// ----------------------------------------
module leic_host_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       pinOut,
  input  wire logic       pinOe_n,
  output logic      [7:0] bootFalls
);
  logic lineLvl;
  logic lineLvl_q;
  // Board pull-up holds a released line high
  assign lineLvl = pinOe_n ? 1'b1 : pinOut;
  // Each falling line edge read as boot finished
  always_ff @(posedge core_clk) begin
    lineLvl_q <= lineLvl;
    if (rst) begin
      bootFalls <= 8'h00;
    end else if (lineLvl_q && !lineLvl) begin
      bootFalls <= bootFalls + 8'h01;
    end
  end
endmodule

// [bench/leic_irq_ctrl_test.sv]
`timescale 1ns/100ps
module leic_irq_ctrl_test;
  import leic_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  clkEn = 1'b1;
  logic                  bootDone = 1'b0;
  logic                  loopLock = 1'b0;
  logic                  clk32k = 1'b0;
  logic [NUM_PERIPH-1:0] periphEvent = '0;
  logic [NUM_GPIO-1:0]   gpioPin = '0;
  logic [NUM_GPIO-1:0]   gpioDebounceEnable = '0;
  logic [NUM_GPIO-1:0]   gpioRisingTriggerSelect = 4'hF;
  logic [NUM_GPIO-1:0]   gpioFallingTriggerSelect = 4'hF;
  logic [NUM_FLAGS-1:0]  flagClearWrite = '0;
  logic [NUM_FLAGS-1:0]  maskWrite = '0;
  logic [2:0]            pinCfgWrite = 3'h0;
  logic                  flagClearStrobe = 1'b0;
  logic                  maskStrobe = 1'b0;
  logic                  pinCfgStrobe = 1'b0;
  logic [NUM_FLAGS-1:0]  flags, maskBits, expF, expM;
  logic [NUM_INPUTS-1:0] liveStatus;
  logic [2:0]            cfg;
  logic [7:0]            hostFalls;
  logic                  requestGlobalMask, requestPinPolarity, requestPinDriveType;
  logic                  requestSummaryStatus, requestPinOut, requestPinOe_n, requestGpioOut;
  int                    fails = 0;
  int                    n_checks = 0;
  int                    r, s;

  leic_irq_ctrl i_leic_irq_ctrl (
    .core_clk                 (core_clk),
    .rst                      (rst),
    .clkEn                    (clkEn),
    .bootDone                 (bootDone),
    .loopLock                 (loopLock),
    .periphEvent              (periphEvent),
    .gpioPin                  (gpioPin),
    .clk32k                   (clk32k),
    .gpioDebounceEnable       (gpioDebounceEnable),
    .gpioRisingTriggerSelect  (gpioRisingTriggerSelect),
    .gpioFallingTriggerSelect (gpioFallingTriggerSelect),
    .flagClearWrite           (flagClearWrite),
    .flagClearStrobe          (flagClearStrobe),
    .maskWrite                (maskWrite),
    .maskStrobe               (maskStrobe),
    .pinCfgWrite              (pinCfgWrite),
    .pinCfgStrobe             (pinCfgStrobe),
    .flags                    (flags),
    .maskBits                 (maskBits),
    .liveStatus               (liveStatus),
    .requestGlobalMask        (requestGlobalMask),
    .requestPinPolarity       (requestPinPolarity),
    .requestPinDriveType      (requestPinDriveType),
    .requestSummaryStatus     (requestSummaryStatus),
    .requestPinOut            (requestPinOut),
    .requestPinOe_n           (requestPinOe_n),
    .requestGpioOut           (requestGpioOut)
  );
  leic_host_model i_leic_host_model (.core_clk(core_clk), .rst(rst), .pinOut(requestPinOut),
    .pinOe_n(requestPinOe_n), .bootFalls(hostFalls));

  always #50 core_clk = ~core_clk;
  // Debounce needs its slow clock kept running
  always #15625 clk32k = ~clk32k;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [NUM_FLAGS-1:0] got, input logic [NUM_FLAGS-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // Kind 0 clear flags, 1 load mask, 2 pin config
  task wr(input int k, input logic [NUM_FLAGS-1:0] v);
    @(posedge core_clk);
    flagClearWrite <= v;
    maskWrite <= v;
    pinCfgWrite <= v[2:0];
    flagClearStrobe <= (k == 0);
    maskStrobe <= (k == 1);
    pinCfgStrobe <= (k == 2);
    @(posedge core_clk);
    {flagClearStrobe, maskStrobe, pinCfgStrobe} <= 3'h0;
    @(negedge core_clk);
    if (k == 0) expF &= ~v;
    else if (k == 1) expM = v;
    else cfg = v[2:0];
  endtask
  function automatic logic reqExp();
    return |(expF & ~expM) & ~cfg[2];
  endfunction
  task outs();
    chk(flags, expF);
    chk(requestSummaryStatus, |(expF & ~expM));
    chk(requestGpioOut, reqExp());
    chk(requestPinOut, reqExp() ^ cfg[1]);
    chk(requestPinOe_n, cfg[0] & (reqExp() ^ cfg[1]));
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Generous bound, the run needs about 3300 cycles
  initial begin
    #(2000000);
    fails++;
    close_out();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    r = $urandom(32'h69B9);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    expF = '0;
    expM = MASK_RESET;
    cfg = 3'h3;
    chk(maskBits, MASK_RESET);
    chk({requestGlobalMask, requestPinPolarity, requestPinDriveType}, 3'h3);
    outs();
    $display("end of test reset");
    @(posedge core_clk) bootDone <= 1'b1;
    wt(2);
    expF[FLAG_BOOT] = 1'b1;
    outs();
    chk(hostFalls, 8'h01);
    wr(0, 15'h0001);
    outs();
    $display("end of test boot");
    // Edges on masked sources still latch
    for (int k = 0; k < 24; k++) begin
      s = $urandom % 5;
      @(posedge core_clk);
      if (s == 4) begin
        loopLock <= ~loopLock;
        expF[loopLock ? FLAG_LOCK_FALL : FLAG_LOCK_RISE] = 1'b1;
      end else begin
        periphEvent[s] <= ~periphEvent[s];
        if (!periphEvent[s]) expF[FLAG_PERIPH0 + s] = 1'b1;
      end
      wt(2);
      outs();
      chk(liveStatus[5:0], {periphEvent, loopLock, bootDone});
    end
    wr(0, 15'($urandom));
    outs();
    wr(1, 15'h0000);
    outs();
    $display("end of test sources");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        wr(2, 15'(c));
        outs();
      end
      wr(0, 15'h7FFF);
    end
    wr(2, 15'h0003);
    $display("end of test pin modes");
    for (int i = 0; i < NUM_GPIO; i++) begin
      @(posedge core_clk) gpioPin[i] <= 1'b1;
      wt(6);
      expF[FLAG_GPIO_RISE + i] = 1'b1;
      outs();
      @(posedge core_clk) gpioPin[i] <= 1'b0;
      wt(6);
      expF[FLAG_GPIO_FALL + i] = 1'b1;
      outs();
    end
    // Frozen clock enable holds every flag; the edge lands on resume
    @(posedge core_clk) clkEn <= 1'b0;
    loopLock <= ~loopLock;
    wt(4);
    chk(flags, expF);
    @(posedge core_clk) clkEn <= 1'b1;
    wt(2);
    expF[loopLock ? FLAG_LOCK_RISE : FLAG_LOCK_FALL] = 1'b1;
    chk(flags, expF);
    wr(0, 15'h7FFF);
    // Level mode keeps setting the flag while high
    @(posedge core_clk);
    gpioRisingTriggerSelect[0] <= 1'b0;
    gpioPin[0] <= 1'b1;
    wt(6);
    wr(0, 15'h7FFF);
    wt(2);
    expF[FLAG_GPIO_RISE] = 1'b1;
    chk(flags, expF);
    @(posedge core_clk) gpioRisingTriggerSelect[0] <= 1'b1;
    gpioPin[0] <= 1'b0;
    wt(6);
    wr(0, 15'h7FFF);
    wt(2);
    chk(flags, 15'h0000);
    // Low level with fall select clear refires the fall flag
    @(posedge core_clk) gpioFallingTriggerSelect[2] <= 1'b0;
    wt(2);
    wr(0, 15'h7FFF);
    wt(2);
    chk(flags, NUM_FLAGS'(1) << (FLAG_GPIO_FALL + 2));
    @(posedge core_clk) gpioFallingTriggerSelect[2] <= 1'b1;
    wr(0, 15'h7FFF);
    wt(2);
    chk(flags, 15'h0000);
    $display("end of test gpio");
    // Short glitch must be filtered out
    @(posedge core_clk) gpioDebounceEnable[1] <= 1'b1;
    @(posedge core_clk) gpioPin[1] <= 1'b1;
    repeat (3) @(posedge core_clk);
    gpioPin[1] <= 1'b0;
    wt(1500);
    chk(flags, 15'h0000);
    @(posedge core_clk) gpioPin[1] <= 1'b1;
    wt(1500);
    chk(liveStatus[7], 1'b1);
    expF[FLAG_GPIO_RISE + 1] = 1'b1;
    chk(flags, expF);
    $display("end of test debounce");
    close_out();
  end
endmodule
